// *** bench/test_tcit_timer.sv ***
// Self-checking bench for the three-channel interval timer top.
// Assumes the byte port strobes and synchronous pin levels of tcit_timer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
	fails++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
	end end
module test_tcit_timer;
	logic core_clk_i, reset_i, wr_en_i, rd_en_i;
	logic [4:0] addr_i;
	logic [7:0] wr_data_i, rd_data_o;
	logic [2:0] ctr_clk_i, gate_i, out_o;
	int fails, n_checks;
	int lowcnt [3];
	logic [31:0] seed;
	logic [15:0] v, e0, e1, n1;

	tcit_timer i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.addr_i(addr_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
		.wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
		.ctr_clk_i(ctr_clk_i), .gate_i(gate_i), .out_o(out_o));

	// Clock at 125 MHz
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	// Pseudo-random source for counts
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// One byte write, one strobe cycle
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1'b1;
		@(posedge core_clk_i);
		wr_en_i <= 1'b0;
	endtask

	// One byte read; data is taken the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge core_clk_i);
		rd_en_i <= 1'b0;
		#1 d = rd_data_o;
	endtask

	// Counts move low byte first, then high byte
	task automatic wr16(input logic [4:0] a, input logic [15:0] c);
		wr(a, c[7:0]);
		wr(a, c[15:8]);
	endtask

	task automatic rd16(input logic [4:0] a, output logic [15:0] c);
		rd(a, c[7:0]);
		rd(a, c[15:8]);
	endtask

	// Counter clock falls on the masked pins; output sampled after each
	task automatic pulse(input logic [2:0] m, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk_i);
			ctr_clk_i <= ctr_clk_i & ~m;
			repeat (5) @(posedge core_clk_i);
			#1;
			for (int c = 0; c < 3; c++) begin
				if (m[c] && out_o[c] === 1'b0) begin
					lowcnt[c]++;
				end
			end
			@(posedge core_clk_i);
			ctr_clk_i <= ctr_clk_i | m;
			repeat (3) @(posedge core_clk_i);
		end
	endtask

	// Program a counter, write its count and let it load
	task automatic setup(input logic [7:0] cw, input logic [4:0] a,
		input logic [15:0] c, input logic [2:0] m);
		wr(5'h1E, cw);
		wr16(a, c);
		pulse(m, 1);
		lowcnt = '{0, 0, 0};
	endtask

	task automatic results;
		if (fails == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial begin
		#400000;
		fails++;
		results();
	end

	initial begin
		reset_i = 1'b1;
		{wr_en_i, rd_en_i} = 2'b00;
		addr_i = 5'h00;
		wr_data_i = 8'h00;
		ctr_clk_i = 3'h7;
		gate_i = 3'h7;
		fails = 0;
		n_checks = 0;
		lowcnt = '{0, 0, 0};
		seed = 32'h4828;
		repeat (16) @(posedge core_clk_i);
		reset_i <= 1'b0;
		@(posedge core_clk_i);
		#1 `CHK("out after reset", 3'h0, out_o)
		// Mode 0 on counter 0, count 5, runs past terminal count
		wr(5'h1E, 8'h30);
		#1 `CHK("mode0 out", 1'b0, out_o[0])
		setup(8'h30, 5'h18, 16'h0005, 3'h1);
		pulse(3'h1, 3);
		#1 `CHK("mode0 before tc", 1'b0, out_o[0])
		pulse(3'h1, 4);
		#1 `CHK("mode0 after tc", 1'b1, out_o[0])
		// Latch freezes the value; a second latch is ignored
		wr(5'h1E, 8'h00);
		pulse(3'h1, 2);
		wr(5'h1E, 8'h00);
		rd16(5'h18, v);
		`CHK("latched count", 16'hFFFE, v)
		e0 = 16'hFFFC;
		// Status read-back of counter 0
		wr(5'h1E, 8'hE2);
		rd(5'h18, v[7:0]);
		`CHK("status byte", 8'hF0, v[7:0])
		// Random count in mode 2 on counter 1, joint latch of 0 and 1
		seed = lfsr_next(seed);
		n1 = {4'h1, seed[11:0]};
		setup(8'h74, 5'h1A, n1, 3'h2);
		pulse(3'h3, 3);
		e0 = e0 - 16'h0003;
		e1 = n1 - 16'h0003;
		wr(5'h1E, 8'hD6);
		rd16(5'h18, v);
		`CHK("readback ctr0", e0, v)
		rd16(5'h1A, v);
		`CHK("readback ctr1", e1, v)
		// Decimal count borrows across digits
		setup(8'hB1, 5'h1C, 16'h0010, 3'h4);
		pulse(3'h4, 2);
		wr(5'h1E, 8'h80);
		rd16(5'h1C, v);
		`CHK("bcd count", 16'h0008, v)
		// Low byte only access
		wr(5'h1E, 8'h90);
		wr(5'h1C, 8'h07);
		pulse(3'h4, 1);
		wr(5'h1E, 8'h80);
		rd(5'h1C, v[7:0]);
		`CHK("low only", 8'h07, v[7:0])
		// Mode 2, N=3: one low sample per period
		setup(8'hB4, 5'h1C, 16'h0003, 3'h4);
		pulse(3'h4, 12);
		`CHK("rate lows", 4, lowcnt[2])
		gate_i[2] <= 1'b0;
		repeat (6) @(posedge core_clk_i);
		#1 `CHK("rate gate low", 1'b1, out_o[2])
		@(posedge core_clk_i);
		gate_i[2] <= 1'b1;
		// Mode 3 via code 111, even then odd count
		setup(8'hBE, 5'h1C, 16'h0004, 3'h4);
		pulse(3'h4, 16);
		`CHK("square even", 8, lowcnt[2])
		setup(8'hBE, 5'h1C, 16'h0005, 3'h4);
		pulse(3'h4, 20);
		`CHK("square odd", 8, lowcnt[2])
		// Mode 4 on counter 1, gate low holds the count
		gate_i[1] <= 1'b0;
		wr(5'h1E, 8'h78);
		#1 `CHK("mode4 out", 1'b1, out_o[1])
		setup(8'h78, 5'h1A, 16'h0003, 3'h2);
		pulse(3'h2, 6);
		`CHK("mode4 inhibit", 0, lowcnt[1])
		gate_i[1] <= 1'b1;
		pulse(3'h2, 8);
		`CHK("mode4 strobe", 1, lowcnt[1])
		// Mode 1 on counter 0, gate rise starts an N-long low pulse
		gate_i[0] <= 1'b0;
		setup(8'h32, 5'h18, 16'h0004, 3'h1);
		#1 `CHK("mode1 idle", 1'b1, out_o[0])
		@(posedge core_clk_i);
		gate_i[0] <= 1'b1;
		pulse(3'h1, 8);
		`CHK("mode1 pulse", 4, lowcnt[0])
		// Mode 5, nothing until a gate rise
		gate_i[0] <= 1'b0;
		setup(8'h3A, 5'h18, 16'h0003, 3'h1);
		pulse(3'h1, 6);
		`CHK("mode5 idle", 0, lowcnt[0])
		gate_i[0] <= 1'b1;
		pulse(3'h1, 8);
		`CHK("mode5 strobe", 1, lowcnt[0])
		// Offset outside the map reads zero
		rd(5'h05, v[7:0]);
		`CHK("unmapped read", 8'h00, v[7:0])
		results();
	end
endmodule
`undef CHK
`default_nettype wire

// *** verilog/tcit_pin_edge.sv ***
// Pin conditioner for one counter: clock falls, gate level and gate rises.
// Assumes the pins are already synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module tcit_pin_edge (
	input wire logic core_clk_i, // Core clock
	input wire logic reset_i, // Synchronous reset, high
	input wire logic ctr_clk_i, // Counter clock pin
	input wire logic gate_i, // Counter gate pin
	output var tcit_pkg::tcit_pin_t pin_o // Registered pin events
);

	logic clk_prev_reg;
	logic gate_prev_reg;

	// Remember the previous pin levels; in reset they follow the pins
	// so that a pin idling high gives no false edge after release
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			clk_prev_reg <= ctr_clk_i;
			gate_prev_reg <= gate_i;
		end else begin
			clk_prev_reg <= ctr_clk_i;
			gate_prev_reg <= gate_i;
		end
	end

	// One-cycle event pulses and the gate level, all registered
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pin_o <= '0;
		end else begin
			pin_o.clk_fall <= clk_prev_reg & ~ctr_clk_i;
			pin_o.gate_rise <= ~gate_prev_reg & gate_i;
			pin_o.gate <= gate_i;
		end
	end

endmodule
`default_nettype wire

// *** verilog/tcit_pkg.sv ***
// Constants, types and helpers shared by the three-channel interval timer.
// Assumes a byte-wide host port and one core clock; no other package.
package tcit_pkg;

	// Host port offsets
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFF_DATA_ZERO = 5'h18;
	localparam logic [4:0] OFF_DATA_ONE = 5'h1A;
	localparam logic [4:0] OFF_DATA_TWO = 5'h1C;
	localparam logic [4:0] OFF_CTRL = 5'h1E;
	localparam logic [1:0] CHAN_NONE = 2'h3;

	// Control word field positions
	localparam int BIT_TARGET_SELECT_HIGH = 7;
	localparam int BIT_TARGET_SELECT_LOW = 6;
	localparam int BIT_BYTE_ACCESS_HIGH = 5;
	localparam int BIT_BYTE_ACCESS_LOW = 4;
	localparam int BIT_MODE_CODE_BIT2 = 3;
	localparam int BIT_MODE_CODE_BIT0 = 1;
	localparam int BIT_COUNT_FORMAT = 0;
	localparam int BIT_LATCH_COUNTS_N = 5;
	localparam int BIT_LATCH_STATUS_N = 4;
	localparam int BIT_READBACK_PICK_ZERO = 1;

	// Field codes
	localparam logic [1:0] SEL_READBACK = 2'h3;
	localparam logic [1:0] ACC_LATCH = 2'h0;
	localparam logic [1:0] ACC_LOW = 2'h1;
	localparam logic [1:0] ACC_HIGH = 2'h2;
	localparam logic [1:0] ACC_BOTH = 2'h3;

	// Count steps
	localparam logic [1:0] STEP_ONE = 2'h1;
	localparam logic [1:0] STEP_TWO = 2'h2;
	localparam logic [1:0] STEP_THREE = 2'h3;

	// Values after reset
	localparam logic [5:0] CTL_RST = 6'h00;
	localparam logic OUT_RST = 1'b0;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [7:0] DATA_RST = 8'h00;

	// Programmed settings of one counter, status bits 5:0
	typedef struct packed {
		logic [1:0] access;
		logic [2:0] mode;
		logic bcd;
	} tcit_ctl_t;

	// Conditioned pin events of one counter
	typedef struct packed {
		logic clk_fall;
		logic gate_rise;
		logic gate;
	} tcit_pin_t;

	typedef enum logic [2:0] {
		TCIT_TC_INT, TCIT_ONE_SHOT, TCIT_RATE,
		TCIT_SQUARE, TCIT_SW_STROBE, TCIT_HW_STROBE
	} tcit_mode_t;

	// Mode code to mode; top bit is a don't-care for modes 2 and 3
	function automatic tcit_mode_t eff_mode(input logic [2:0] m);
		if (m[1]) begin
			return tcit_mode_t'({1'b0, m[1:0]});
		end
		return tcit_mode_t'(m);
	endfunction

	// Data port offset to counter index
	function automatic logic [1:0] chan_of(input logic [4:0] a);
		if (a == OFF_DATA_ZERO) begin
			return 2'h0;
		end else if (a == OFF_DATA_ONE) begin
			return 2'h1;
		end else if (a == OFF_DATA_TWO) begin
			return 2'h2;
		end
		return CHAN_NONE;
	endfunction

	// One step down; zero wraps to the top of the range
	function automatic logic [15:0] dec1(input logic [15:0] v,
		input logic bcd);
		logic [15:0] r;
		logic b;
		r = v;
		b = 1'b1;
		if (!bcd) begin
			r = v - 16'h0001;
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (b) begin
					if (r[4*k +: 4] == 4'h0) begin
						r[4*k +: 4] = 4'h9;
					end else begin
						r[4*k +: 4] = r[4*k +: 4] - 4'h1;
						b = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	// Several steps down, one to three
	function automatic logic [15:0] dec_by(input logic [15:0] v,
		input logic [1:0] n, input logic bcd);
		logic [15:0] r;
		r = v;
		for (int k = 0; k < 3; k++) begin
			if (k < int'(n)) begin
				r = dec1(r, bcd);
			end
		end
		return r;
	endfunction

endpackage

// *** verilog/tcit_timer.sv ***
// Three-channel interval timer: host byte port, three counters and pins.
// Assumes a byte-wide host port with one-cycle read and write strobes.
`timescale 1ns/1ps
`default_nettype none
module tcit_timer (
	input wire logic core_clk_i, // Core clock, 125 MHz
	input wire logic reset_i, // Synchronous reset, high
	input wire logic [4:0] addr_i, // Port offset
	input wire logic wr_en_i, // Write strobe
	input wire logic rd_en_i, // Read strobe
	input wire logic [7:0] wr_data_i, // Write byte
	output logic [7:0] rd_data_o, // Read byte, next cycle
	input wire logic [2:0] ctr_clk_i, // Counter clock pins
	input wire logic [2:0] gate_i, // Counter gate pins
	output logic [2:0] out_o // Counter output pins
);

	tcit_pkg::tcit_pin_t pin [3];
	tcit_pkg::tcit_ctl_t ctl_reg [3];
	tcit_pkg::tcit_mode_t eff [3];
	logic [15:0] cr_reg [3];
	logic [15:0] ce_reg [3];
	logic [15:0] ol_reg [3];
	logic [15:0] nxt [3];
	logic [7:0] lsb_reg [3];
	logic [7:0] sts_reg [3];
	logic [1:0] step [3];
	logic [2:0] wr_hi_reg, halt_reg, load_reg, run_reg, trig_reg;
	logic [2:0] first_reg, null_reg, out_reg, armed_reg;
	logic [2:0] count_held_reg, sts_held_reg, rd_hi_reg;
	logic [2:0] ctl_wr, latch_cmd, rb_count, rb_sts, dat_wr, dat_rd;
	logic [2:0] wr_done;
	logic [7:0] rd_data_reg;
	logic [1:0] rch;
	logic [15:0] rd_word;
	logic [7:0] rd_byte;
	logic ctl_hit;
	logic [1:0] sel;

	// Pin conditioning per counter
	for (genvar g = 0; g < 3; g++) begin : g_pin
		tcit_pin_edge u_pin (
			.core_clk_i(core_clk_i),
			.reset_i(reset_i),
			.ctr_clk_i(ctr_clk_i[g]),
			.gate_i(gate_i[g]),
			.pin_o(pin[g])
		);
	end

	// Host port decode
	always_comb begin
		ctl_hit = wr_en_i && (addr_i == tcit_pkg::OFF_CTRL);
		sel = wr_data_i[tcit_pkg::BIT_TARGET_SELECT_HIGH:
			tcit_pkg::BIT_TARGET_SELECT_LOW];
		for (int i = 0; i < 3; i++) begin
			dat_wr[i] = wr_en_i && (tcit_pkg::chan_of(addr_i) == 2'(i));
			dat_rd[i] = rd_en_i && (tcit_pkg::chan_of(addr_i) == 2'(i));
			ctl_wr[i] = ctl_hit && (sel == 2'(i)) &&
				(wr_data_i[5:4] != tcit_pkg::ACC_LATCH);
			latch_cmd[i] = ctl_hit && (sel == 2'(i)) &&
				(wr_data_i[5:4] == tcit_pkg::ACC_LATCH);
			rb_count[i] = ctl_hit && (sel == tcit_pkg::SEL_READBACK) &&
				!wr_data_i[tcit_pkg::BIT_LATCH_COUNTS_N] &&
				wr_data_i[tcit_pkg::BIT_READBACK_PICK_ZERO + i];
			rb_sts[i] = ctl_hit && (sel == tcit_pkg::SEL_READBACK) &&
				!wr_data_i[tcit_pkg::BIT_LATCH_STATUS_N] &&
				wr_data_i[tcit_pkg::BIT_READBACK_PICK_ZERO + i];
			wr_done[i] = dat_wr[i] &&
				((ctl_reg[i].access == tcit_pkg::ACC_LOW) ||
				(ctl_reg[i].access == tcit_pkg::ACC_HIGH) ||
				(ctl_reg[i].access == tcit_pkg::ACC_BOTH && wr_hi_reg[i]));
		end
	end

	// Effective mode and next count value per counter
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			eff[i] = tcit_pkg::eff_mode(ctl_reg[i].mode);
			step[i] = tcit_pkg::STEP_ONE;
			if (eff[i] == tcit_pkg::TCIT_SQUARE) begin
				if (first_reg[i] && cr_reg[i][0]) begin
					step[i] = out_reg[i] ? tcit_pkg::STEP_ONE :
						tcit_pkg::STEP_THREE;
				end else begin
					step[i] = tcit_pkg::STEP_TWO;
				end
			end
			nxt[i] = tcit_pkg::dec_by(ce_reg[i], step[i],
				ctl_reg[i].bcd);
		end
	end

	// Control word and count register programming
	always_ff @(posedge core_clk_i) begin
		for (int i = 0; i < 3; i++) begin
			if (reset_i) begin
				ctl_reg[i] <= tcit_pkg::tcit_ctl_t'(tcit_pkg::CTL_RST);
				cr_reg[i] <= tcit_pkg::COUNT_RST;
				lsb_reg[i] <= tcit_pkg::DATA_RST;
				wr_hi_reg[i] <= 1'b0;
				halt_reg[i] <= 1'b0;
			end else if (ctl_wr[i]) begin
				ctl_reg[i] <= tcit_pkg::tcit_ctl_t'(wr_data_i[5:0]);
				wr_hi_reg[i] <= 1'b0;
				halt_reg[i] <= 1'b0;
			end else if (dat_wr[i]) begin
				case (ctl_reg[i].access)
					tcit_pkg::ACC_LOW: begin
						cr_reg[i] <= {8'h00, wr_data_i};
					end
					tcit_pkg::ACC_HIGH: begin
						cr_reg[i] <= {wr_data_i, 8'h00};
					end
					tcit_pkg::ACC_BOTH: begin
						if (!wr_hi_reg[i]) begin
							lsb_reg[i] <= wr_data_i;
							wr_hi_reg[i] <= 1'b1;
							halt_reg[i] <= 1'b1;
						end else begin
							cr_reg[i] <= {wr_data_i, lsb_reg[i]};
							wr_hi_reg[i] <= 1'b0;
							halt_reg[i] <= 1'b0;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Counting element, output pin and load bookkeeping
	always_ff @(posedge core_clk_i) begin
		for (int i = 0; i < 3; i++) begin
			if (reset_i) begin
				ce_reg[i] <= tcit_pkg::COUNT_RST;
				out_reg[i] <= tcit_pkg::OUT_RST;
				{load_reg[i], run_reg[i], trig_reg[i]} <= 3'h0;
				{first_reg[i], null_reg[i], armed_reg[i]} <= 3'h0;
			end else if (ctl_wr[i]) begin
				// Mode 0 starts low, every other mode starts high
				out_reg[i] <= (tcit_pkg::eff_mode(wr_data_i[3:1]) !=
					tcit_pkg::TCIT_TC_INT);
				{load_reg[i], run_reg[i], trig_reg[i]} <= 3'h0;
				{first_reg[i], null_reg[i], armed_reg[i]} <= 3'h0;
			end else begin
				// Gate low holds the periodic modes high
				if ((eff[i] == tcit_pkg::TCIT_RATE ||
					eff[i] == tcit_pkg::TCIT_SQUARE) && !pin[i].gate) begin
					out_reg[i] <= 1'b1;
				end
				if (pin[i].clk_fall) begin
					trig_reg[i] <= 1'b0;
					case (eff[i])
						tcit_pkg::TCIT_TC_INT: begin
							if (load_reg[i]) begin
								ce_reg[i] <= cr_reg[i];
								{load_reg[i], null_reg[i]} <= 2'h1;
								run_reg[i] <= 1'b1;
								out_reg[i] <= 1'b0;
							end else if (run_reg[i] && pin[i].gate &&
								!halt_reg[i]) begin
								ce_reg[i] <= nxt[i];
								if (nxt[i] == 16'h0000) begin
									out_reg[i] <= 1'b1;
								end
							end
						end
						tcit_pkg::TCIT_ONE_SHOT: begin
							if (trig_reg[i] && armed_reg[i]) begin
								ce_reg[i] <= cr_reg[i];
								{load_reg[i], null_reg[i]} <= 2'h1;
								run_reg[i] <= 1'b1;
								out_reg[i] <= 1'b0;
							end else if (run_reg[i]) begin
								ce_reg[i] <= nxt[i];
								if (nxt[i] == 16'h0000) begin
									out_reg[i] <= 1'b1;
								end
							end
						end
						tcit_pkg::TCIT_RATE, tcit_pkg::TCIT_SQUARE: begin
							if (pin[i].gate) begin
								if (trig_reg[i] ||
									(load_reg[i] && !run_reg[i])) begin
									ce_reg[i] <= cr_reg[i];
									{load_reg[i], null_reg[i]} <= 2'h1;
									run_reg[i] <= armed_reg[i];
									first_reg[i] <= 1'b1;
									out_reg[i] <= 1'b1;
								end else if (run_reg[i]) begin
									first_reg[i] <= 1'b0;
									if (nxt[i] == 16'h0000) begin
										// Reload picks up any new count
										ce_reg[i] <= cr_reg[i];
										{load_reg[i], null_reg[i]} <= 2'h1;
										first_reg[i] <= 1'b1;
										out_reg[i] <= (eff[i] ==
											tcit_pkg::TCIT_RATE) ?
											1'b1 : ~out_reg[i];
									end else begin
										ce_reg[i] <= nxt[i];
										if (eff[i] == tcit_pkg::TCIT_RATE &&
											nxt[i] == 16'h0001) begin
											out_reg[i] <= 1'b0;
										end
									end
								end
							end
						end
						default: begin
							// Strobe modes: a low lasts one counter clock
							if (!out_reg[i]) begin
								out_reg[i] <= 1'b1;
							end
							if (eff[i] == tcit_pkg::TCIT_SW_STROBE ?
								load_reg[i] :
								(trig_reg[i] && armed_reg[i])) begin
								ce_reg[i] <= cr_reg[i];
								{load_reg[i], null_reg[i]} <= 2'h1;
								run_reg[i] <= 1'b1;
							end else if (run_reg[i] && (pin[i].gate ||
								eff[i] == tcit_pkg::TCIT_HW_STROBE)) begin
								ce_reg[i] <= nxt[i];
								if (nxt[i] == 16'h0000) begin
									out_reg[i] <= 1'b0;
									run_reg[i] <= 1'b0;
								end
							end
						end
					endcase
				end
				// New events win over their consumption
				if (pin[i].gate_rise) begin
					trig_reg[i] <= 1'b1;
				end
				if (wr_done[i]) begin
					{load_reg[i], null_reg[i]} <= 2'h2;
					armed_reg[i] <= 1'b1;
				end
			end
		end
	end

	// Count and status latches
	always_ff @(posedge core_clk_i) begin
		for (int i = 0; i < 3; i++) begin
			if (reset_i) begin
				ol_reg[i] <= tcit_pkg::COUNT_RST;
				sts_reg[i] <= tcit_pkg::DATA_RST;
				{count_held_reg[i], sts_held_reg[i], rd_hi_reg[i]} <= 3'h0;
			end else begin
				if (ctl_wr[i]) begin
					{count_held_reg[i], sts_held_reg[i], rd_hi_reg[i]} <= 3'h0;
				end else if (dat_rd[i]) begin
					if (sts_held_reg[i]) begin
						sts_held_reg[i] <= 1'b0;
					end else if (ctl_reg[i].access == tcit_pkg::ACC_BOTH &&
						!rd_hi_reg[i]) begin
						rd_hi_reg[i] <= 1'b1;
					end else begin
						rd_hi_reg[i] <= 1'b0;
						count_held_reg[i] <= 1'b0;
					end
				end
				// Later latch requests are dropped while one is held
				if ((latch_cmd[i] || rb_count[i]) && !count_held_reg[i]) begin
					ol_reg[i] <= ce_reg[i];
					count_held_reg[i] <= 1'b1;
				end
				if (rb_sts[i] && !sts_held_reg[i]) begin
					sts_reg[i] <= {out_reg[i], null_reg[i], ctl_reg[i]};
					sts_held_reg[i] <= 1'b1;
				end
			end
		end
	end

	// Byte presented by the addressed data port
	always_comb begin
		rch = tcit_pkg::chan_of(addr_i);
		rd_word = tcit_pkg::COUNT_RST;
		rd_byte = tcit_pkg::DATA_RST;
		if (rch != tcit_pkg::CHAN_NONE) begin
			rd_word = count_held_reg[rch] ? ol_reg[rch] : ce_reg[rch];
			if (sts_held_reg[rch]) begin
				rd_byte = sts_reg[rch];
			end else if (ctl_reg[rch].access == tcit_pkg::ACC_HIGH ||
				(ctl_reg[rch].access == tcit_pkg::ACC_BOTH &&
				rd_hi_reg[rch])) begin
				rd_byte = rd_word[15:8];
			end else begin
				rd_byte = rd_word[7:0];
			end
		end
	end

	// Read data register
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rd_data_reg <= tcit_pkg::DATA_RST;
		end else if (rd_en_i) begin
			rd_data_reg <= rd_byte;
		end
	end

	assign rd_data_o = rd_data_reg;
	assign out_o = out_reg;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	property p_unmapped_read;
		rd_en_i && tcit_pkg::chan_of(addr_i) == tcit_pkg::CHAN_NONE
			|=> rd_data_o == 8'h00;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read returned nonzero");

	property p_readback_all;
		ctl_hit && sel == tcit_pkg::SEL_READBACK &&
			!wr_data_i[tcit_pkg::BIT_LATCH_COUNTS_N] &&
			count_held_reg == 3'h0
			|=> count_held_reg == $past(wr_data_i[3:1]);
	endproperty
	a_readback_all: assert property (p_readback_all)
		else $error("read-back did not latch all counters");

	for (genvar g = 0; g < 3; g++) begin : g_chk
		sequence s_latch_cmd;
			latch_cmd[g] && !count_held_reg[g];
		endsequence
		property p_latch_take;
			s_latch_cmd |=> count_held_reg[g] && ol_reg[g] == $past(ce_reg[g]);
		endproperty
		a_latch_take: assert property (p_latch_take)
			else $error("latch did not capture count");

		property p_latch_frozen;
			count_held_reg[g] && !dat_rd[g] && !ctl_wr[g] |=> $stable(ol_reg[g]);
		endproperty
		a_latch_frozen: assert property (p_latch_frozen)
			else $error("held count changed before read");

		property p_mode0_low;
			ctl_wr[g] && wr_data_i[3:1] == 3'h0 |=> !out_reg[g];
		endproperty
		a_mode0_low: assert property (p_mode0_low)
			else $error("mode 0 setup left output high");

		property p_status_fmt;
			rb_sts[g] && !sts_held_reg[g] |=> sts_held_reg[g] &&
				sts_reg[g][7] == $past(out_reg[g]) &&
				sts_reg[g][5:0] == $past(ctl_reg[g]);
		endproperty
		a_status_fmt: assert property (p_status_fmt)
			else $error("status byte wrong");

		property p_status_read;
			sts_held_reg[g] && dat_rd[g] |=> rd_data_o == $past(sts_reg[g]) &&
				!sts_held_reg[g];
		endproperty
		a_status_read: assert property (p_status_read)
			else $error("status not returned on read");

		property p_rate_gate;
			eff[g] == tcit_pkg::TCIT_RATE && !pin[g].gate && !ctl_wr[g]
				|=> out_reg[g];
		endproperty
		a_rate_gate: assert property (p_rate_gate)
			else $error("gate low did not force output high");

		property p_strobe_one;
			(eff[g] == tcit_pkg::TCIT_SW_STROBE ||
				eff[g] == tcit_pkg::TCIT_HW_STROBE) && !out_reg[g] &&
				pin[g].clk_fall && !ctl_wr[g] |=> out_reg[g];
		endproperty
		a_strobe_one: assert property (p_strobe_one)
			else $error("strobe longer than one counter clock");
	end

endmodule
`default_nettype wire
